/* File: design/lpac_pkg.sv */
/*
 * lpac_pkg: constants and carrier types of the link partner ability capture block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses at four times the register index.
 */
package lpac_pkg;

    // register indices and byte addresses
    localparam logic [7:0] ABILITY_IDX = 8'h05;
    localparam logic [7:0] CTRL_IDX = 8'h08;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h09;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h0a;
    localparam logic [7:0] ABILITY_ADDR = 8'h14;
    localparam logic [7:0] CTRL_ADDR = 8'h20;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h24;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h28;

    // ability word fields, both views
    localparam int WANTS_EXTRA_BIT = 15;
    localparam int ACK_BIT = 14;
    localparam int FAR_FAULT_BIT = 13;
    localparam int MESSAGE_PAGE_BIT = 13;
    localparam int RESERVED_BIT = 12;
    localparam int CAN_COMPLY_BIT = 12;
    localparam int ASYM_FLOW_BIT = 11;
    localparam int TOGGLE_BIT = 11;
    localparam int PAUSE_BIT = 10;
    localparam int FOUR_PAIR_BIT = 9;
    localparam int FAST_FULL_BIT = 8;
    localparam int FAST_BIT = 7;
    localparam int SLOW_FULL_BIT = 6;
    localparam int SLOW_BIT = 5;
    localparam int SELECTOR_LSB = 0;
    localparam int SELECTOR_W = 5;
    localparam int CODE_W = 11;

    // control and interrupt fields
    localparam int CTRL_NP_EN_BIT = 0;
    localparam int IRQ_W = 3;
    localparam int EV_BASE_BIT = 0;
    localparam int EV_NEXT_BIT = 1;
    localparam int EV_DONE_BIT = 2;

    // reset values
    localparam logic [15:0] ABILITY_RESET = 16'h0000;
    localparam logic CTRL_NP_EN_RESET = 1'b0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // one received link code word from the negotiation logic
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } lpac_page_s;

    // whole state of the capture block
    typedef struct packed {
        logic [15:0] base_page;
        logic [15:0] next_page;
        logic np_view;
        logic done_d;
        logic np_en;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic ack;
        logic [31:0] dat;
    } lpac_state_s;

endpackage

/* File: design/lpac_capture.sv */
/*
 * lpac_capture: holds the abilities the remote link partner advertised during
 * auto-negotiation, in a base-page view and a next-page view at one address,
 * with a small control and interrupt register set on classic Wishbone.
 * Assumes the negotiation logic runs on clk_i and hands over each received
 * link code word as a one-cycle valid with its word, plus a level that stays
 * high while negotiation has completed successfully.
 */
// Decided for this implementation: register access over Wishbone.
// Operation
// - partner abilities held in a read-only 16-bit register at index 0x05
// - after successful completion with next pages enabled, show the next-page view; the code switches only on the first next page received after that
// - base view bit 15 shows partner wants extra pages, resets to 0
// - bit 14 is the partner acknowledge taken from received bursts
// - bit 13 shows partner remote fault
// - base view bit 12 reserved, reads 0, software writes 0
// - bit 11 shows partner asymmetric pause support
// - bit 10 shows partner symmetric pause support
// - bit 9 shows partner four-pair ability
// - bit 8 shows partner fast full duplex
// - bit 7 shows partner fast operation
// - bit 6 shows partner slow full duplex
// - bit 5 shows partner slow operation
// - bits 4:0 carry partner protocol selector, reset zero
// - next view bit 15 again shows partner wants extra pages
// - next view bit 12 shows partner can comply
// - next view bit 11 shows toggle value received
// - next view bits 10:0 carry page code, message if bit 13 set
`timescale 1ns/1ps

module lpac_capture (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // negotiation logic side, same clock
    input wire lpac_pkg::lpac_page_s page_i,
    input wire logic an_complete_i,
    // views of the held word, and the interrupt line
    output logic [15:0] partner_ability_word_o,
    output logic next_page_view_o,
    output logic irq_o
);

    lpac_pkg::lpac_state_s state_reg;
    lpac_pkg::lpac_state_s state_next;

    // masks a base page word so the reserved bit always reads zero
    function automatic logic [15:0] base_clean(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[lpac_pkg::RESERVED_BIT] = 1'b0;
        return r;
    endfunction

    // true when the bus address hits the given byte address
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] target);
        return adr == target;
    endfunction

    logic req;
    logic rd;
    logic wr;
    logic rd_stat;
    logic [15:0] shown;
    logic [2:0] events;
    logic done_rise;
    logic np_stage;

    // bus strobes: one answer per request, ack drops the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    assign rd = req & ~wb_we_i;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd_stat = rd & hit(wb_adr_i, lpac_pkg::IRQ_STAT_ADDR);

    // pages after success with next pages enabled belong to the next view
    assign done_rise = an_complete_i & ~state_reg.done_d;
    assign np_stage = an_complete_i & state_reg.np_en;

    // view select: next-page contents replace base contents once staged
    assign shown = state_reg.np_view ? state_reg.next_page : base_clean(state_reg.base_page);

    // events feeding sticky status bits
    always_comb begin
        events = 3'h0;
        events[lpac_pkg::EV_BASE_BIT] = page_i.valid & ~np_stage;
        events[lpac_pkg::EV_NEXT_BIT] = page_i.valid & np_stage;
        events[lpac_pkg::EV_DONE_BIT] = done_rise;
    end

    // next state of the whole block
    always_comb begin
        state_next = state_reg;
        state_next.done_d = an_complete_i;
        // base page fields taken as received except reserved bit 12, which is cleared; bits 15..0 in place
        if (page_i.valid && !np_stage) begin
            state_next.base_page = base_clean(page_i.word);
            // fields 8..0 land unchanged
        end
        // next pages: wants-extra, message flag, comply, toggle, code
        if (page_i.valid && np_stage) begin
            state_next.next_page = page_i.word;
        end
        // view switches on the first next page after success
        if (page_i.valid && np_stage) begin
            state_next.np_view = 1'b1;
        end
        // a new negotiation (complete dropped) returns to the base view
        if (!an_complete_i) begin
            state_next.np_view = 1'b0;
        end
        // writable control and mask; ability index ignores writes
        if (wr && hit(wb_adr_i, lpac_pkg::CTRL_ADDR)) begin
            state_next.np_en = wb_dat_i[lpac_pkg::CTRL_NP_EN_BIT];
        end
        if (wr && hit(wb_adr_i, lpac_pkg::IRQ_MASK_ADDR)) begin
            state_next.irq_mask = wb_dat_i[lpac_pkg::IRQ_W-1:0];
        end
        // no write path to base_page or next_page at all
        // read clears status, but an event in the same cycle is kept
        state_next.irq_status = (rd_stat ? 3'h0 : state_reg.irq_status) | events;
        // registered answer, data sampled with the request
        state_next.ack = req;
        state_next.dat = 32'h0000_0000;
        if (rd) begin
            unique case (1'b1)
                hit(wb_adr_i, lpac_pkg::ABILITY_ADDR): state_next.dat = {16'h0000, shown};
                hit(wb_adr_i, lpac_pkg::CTRL_ADDR): state_next.dat = {31'h0, state_reg.np_en};
                hit(wb_adr_i, lpac_pkg::IRQ_STAT_ADDR): state_next.dat = {29'h0, state_reg.irq_status};
                hit(wb_adr_i, lpac_pkg::IRQ_MASK_ADDR): state_next.dat = {29'h0, state_reg.irq_mask};
                default: state_next.dat = 32'h0000_0000; // unmapped reads give zero
            endcase
        end
    end

    // single register stage, synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.base_page <= lpac_pkg::ABILITY_RESET;
            state_reg.next_page <= lpac_pkg::ABILITY_RESET;
            state_reg.np_view <= 1'b0;
            state_reg.done_d <= 1'b0;
            state_reg.np_en <= lpac_pkg::CTRL_NP_EN_RESET;
            state_reg.irq_status <= 3'h0;
            state_reg.irq_mask <= lpac_pkg::IRQ_MASK_RESET;
            state_reg.ack <= 1'b0;
            state_reg.dat <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from state
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.dat;
    assign partner_ability_word_o = shown;
    assign next_page_view_o = state_reg.np_view;
    assign irq_o = |(state_reg.irq_status & state_reg.irq_mask);

endmodule

/* File: sim/lpac_partner.sv */
/* lpac_partner: negotiation side model feeding received code words.
   Assumes the capture block samples page_o on clk_i. */
`timescale 1ns/1ps
module lpac_partner (
    input wire logic clk_i,
    output lpac_pkg::lpac_page_s page_o,
    output logic an_complete_o
);
    // idle word is inverted so a stale value never looks valid
    initial begin
        page_o = '0;
        an_complete_o = 1'b0;
    end
    // one-cycle valid per word
    task send(input logic [15:0] w);
        @(posedge clk_i);
        page_o <= '{1'b1, w};
        @(posedge clk_i);
        page_o <= '{1'b0, ~w};
    endtask
    // completion level
    task set_done(input logic v);
        @(posedge clk_i);
        an_complete_o <= v;
    endtask
endmodule

/* File: sim/lpac_props.sv */
/* lpac_props: port checks of the capture block.
   Assumes binding onto lpac_capture, one clock. */
`timescale 1ns/1ps
module lpac_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire lpac_pkg::lpac_page_s page_i,
    input wire logic an_complete_i,
    input wire logic [15:0] partner_ability_word_o,
    input wire logic next_page_view_o
);
    // one domain, so clock and reset once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper bits set");
    a_base_rsvd: assert property (!next_page_view_o |-> !partner_ability_word_o[12]) else $error("bit 12");
    a_base_load: assert property (page_i.valid && !an_complete_i |=>
        partner_ability_word_o == ($past(page_i.word) & 16'hefff)) else $error("base word");
    a_next_load: assert property (page_i.valid && an_complete_i && next_page_view_o |=>
        !next_page_view_o || partner_ability_word_o == $past(page_i.word)) else $error("next word");
    a_view_back: assert property (!an_complete_i |=> !next_page_view_o) else $error("view stuck");
    a_word_hold: assert property (!page_i.valid && $stable(an_complete_i) |=>
        $stable(partner_ability_word_o)) else $error("word changed");
endmodule

/* File: sim/lpac_capture_tb.sv */
/* lpac_capture_tb: self-checking bench with queued read expectations.
   Assumes the partner model and the checker bound below. */
`timescale 1ns/1ps
module lpac_capture_tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h0;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic wb_ack_o, an_c, view, irq_o;
    logic [15:0] word, w, b;
    lpac_pkg::lpac_page_s page;
    int miscompares = 0, num_checks = 0, n;
    logic [31:0] q[$];
    always #25 clk_i = ~clk_i;
    lpac_partner p_u (.clk_i(clk_i), .page_o(page), .an_complete_o(an_c));
    lpac_capture dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .page_i(page), .an_complete_i(an_c), .partner_ability_word_o(word),
        .next_page_view_o(view), .irq_o(irq_o));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // classic single cycle, released only after ack is seen
    task wb(input logic w_e, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w_e, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
        {cyc, stb} <= 2'b00;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // read data monitor takes the oldest expectation
    always @(posedge clk_i) if (wb_ack_o === 1'b1 && we === 1'b0) chk("rdata", wb_dat_o, q.pop_front());
    initial begin
        void'($urandom(4));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h14, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h3c, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 16'hffff : $urandom;
            b = w & 16'hefff;
            p_u.send(w);
            rd(8'h14, {16'h0, b});
            wb(1'b1, 8'h14, {16'h0, ~w & 16'hefff});
            rd(8'h14, {16'h0, b});
        end
        $display("test base page done");
        rd(8'h24, 32'h1);
        wb(1'b1, 8'h28, 32'h1);
        p_u.send(w);
        @(negedge clk_i); // let the status register settle before looking
        chk("irq", irq_o, 1'b1);
        rd(8'h24, 32'h1);
        chk("irq", irq_o, 1'b0);
        wb(1'b1, 8'h28, 32'h0);
        p_u.send(w);
        chk("irq", irq_o, 1'b0);
        rd(8'h24, 32'h1);
        $display("test interrupt done");
        wb(1'b1, 8'h20, 32'h1);
        rd(8'h20, 32'h1);
        p_u.set_done(1'b1);
        w = $urandom;
        p_u.send(w);
        @(negedge clk_i);
        chk("view", view, 1'b1);
        rd(8'h14, {16'h0, w});
        rd(8'h24, 32'h6);
        p_u.set_done(1'b0);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("view", view, 1'b0);
        rd(8'h14, {16'h0, b});
        $display("test next page done");
        finish_test();
    end
endmodule
bind lpac_capture lpac_props props_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .page_i(page_i), .an_complete_i(an_complete_i),
    .partner_ability_word_o(partner_ability_word_o), .next_page_view_o(next_page_view_o));
